// ---- bench/rpss_regs_assertions.sv ----
// port checks of the ramp phase, spread and status registers
`timescale 1ns/10ps
module rpss_regs_assertions
  import rpss_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input wire logic              mclk_i,
  input wire logic              reset_n_i,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [31:0]       prdata,
  input wire logic [7:0]        power_state_code_i,
  input wire logic              left_automute_flag_i,
  input wire logic              right_automute_flag_i,
  input wire logic              internal_sync_i,
  input wire logic [1:0]        ramp_phase_o,
  input wire logic              sync_source_internal_o,
  input wire logic              sync_enable_o,
  input wire logic              phase_sync_pulse_o,
  input wire logic              spread_manual_o,
  input wire logic              spread_clk_div2_o,
  input wire logic              random_spread_on_o,
  input wire logic              triangle_spread_on_o,
  input wire logic [3:0]        triangle_setting_o,
  input wire logic [2:0]        random_dither_setting_o
);
  //****
  // access decode
  //****
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  wire logic acc = psel && penable;
  wire logic wr = acc && pwrite && pstrb[0];
  wire logic wr_ph = wr && paddr == ADDR_W'({IDX_PHASE_CTRL, 2'b00});
  wire logic wr_sm = wr && paddr == ADDR_W'({IDX_SPREAD_MODE, 2'b00});
  wire logic wr_sh = wr && paddr == ADDR_W'({IDX_SPREAD_SHAPE, 2'b00});
  wire logic rd_pw = acc && !pwrite && paddr == ADDR_W'({IDX_POWER_STATE, 2'b00});
  wire logic rd_mu = acc && !pwrite && paddr == ADDR_W'({IDX_MUTE_REPORT, 2'b00});

  a_phase_write: assert property (wr_ph |=> ramp_phase_o == $past(pwdata[3:2]))
    else $error("ramp phase not taken from write");
  a_source_write: assert property (wr_ph |=> sync_source_internal_o == $past(pwdata[1]))
    else $error("sync source not taken from write");
  a_enable_write: assert property (wr_ph |=> sync_enable_o == $past(pwdata[0]))
    else $error("sync enable not taken from write");
  a_sync_pulse_internal: assert property (internal_sync_i && sync_enable_o && sync_source_internal_o |=> phase_sync_pulse_o)
    else $error("internal sync gave no pulse");
  a_div2_manual: assert property (wr_sm |=> spread_clk_div2_o == ($past(pwdata[5]) && $past(pwdata[4])))
    else $error("clock halving wrong");
  a_manual_write: assert property (wr_sm |=> spread_manual_o == $past(pwdata[4]))
    else $error("manual mode not taken from write");
  a_spread_enables: assert property (wr_sm |=> {random_spread_on_o, triangle_spread_on_o} == $past(pwdata[1:0]))
    else $error("spread enables wrong");
  a_shape_write: assert property (wr_sh |=> {random_dither_setting_o, triangle_setting_o} == $past(pwdata[6:0]))
    else $error("shape fields wrong");
  a_power_read: assert property (rd_pw |-> prdata == {24'h0, $past(power_state_code_i, 2)})
    else $error("power state read wrong");
  a_mute_read: assert property (rd_mu |-> prdata == {30'h0, $past(right_automute_flag_i, 2), $past(left_automute_flag_i, 2)})
    else $error("mute report read wrong");
endmodule // rpss_regs_assertions

bind rpss_regs rpss_regs_assertions #(.ADDR_W(ADDR_W)) chk_u (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .power_state_code_i(power_state_code_i), .left_automute_flag_i(left_automute_flag_i),
  .right_automute_flag_i(right_automute_flag_i), .internal_sync_i(internal_sync_i), .ramp_phase_o(ramp_phase_o),
  .sync_source_internal_o(sync_source_internal_o), .sync_enable_o(sync_enable_o),
  .phase_sync_pulse_o(phase_sync_pulse_o), .spread_manual_o(spread_manual_o), .spread_clk_div2_o(spread_clk_div2_o),
  .random_spread_on_o(random_spread_on_o), .triangle_spread_on_o(triangle_spread_on_o),
  .triangle_setting_o(triangle_setting_o), .random_dither_setting_o(random_dither_setting_o));

// ---- bench/rpss_regs_tb.sv ----
// self-checking bench of the ramp phase, spread and status registers
`timescale 1ns/10ps
module rpss_regs_tb;
  import rpss_pkg::*;
  logic        mclk_i, reset_n_i, psel, penable, pwrite, pready, pslverr, lm, rm, isy, spin;
  logic        ssrc, sen, spul, sman, sdiv, srnd, stri, irq, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0]  pstrb, tset;
  logic [7:0]  pwr;
  logic [1:0]  ph;
  logic [2:0]  dith;
  int          err_total, check_count, n;
  logic [7:0]  sm [3] = '{8'hff, 8'h20, 8'h12};
  logic [7:0]  rst_idx [7] = '{IDX_POWER_STATE, IDX_MUTE_REPORT, IDX_PHASE_CTRL, IDX_SPREAD_MODE,
                               IDX_SPREAD_SHAPE, IDX_IRQ_STATUS, IDX_IRQ_ENABLE};

  rpss_regs dut_u (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_state_code_i(pwr), .left_automute_flag_i(lm), .right_automute_flag_i(rm), .internal_sync_i(isy),
    .sync_pin_i(spin), .ramp_phase_o(ph), .sync_source_internal_o(ssrc), .sync_enable_o(sen),
    .phase_sync_pulse_o(spul), .spread_manual_o(sman), .spread_clk_div2_o(sdiv), .random_spread_on_o(srnd),
    .triangle_spread_on_o(stri), .triangle_setting_o(tset), .random_dither_setting_o(dith), .irq_o(irq));

  //****
  // bus tasks
  //****
  function automatic logic [11:0] ba(input logic [7:0] i);
    return {2'b00, i, 2'b00};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge mclk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge mclk_i);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk_i);
      n++;
    end
    while (pready !== 1'b1);
    chk("pready", 1, pready);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    apb(1'b1, ba(i), d, 4'hf);
  endtask

  task automatic rdc(input logic [7:0] i, input logic [31:0] e);
    apb(1'b0, ba(i), 32'h0, 4'h0);
    chk("prdata", e, rdat);
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  //****
  // clock, watchdog and tests
  //****
  initial
  begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end

  initial
  begin
    repeat (4000) @(posedge mclk_i);
    err_total++;
    conclude;
  end

  initial
  begin
    {psel, penable, pwrite, lm, rm, isy, spin, reset_n_i} = '0;
    {paddr, pwdata, pstrb, pwr} = '0;
    repeat (6) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    foreach (rst_idx[i]) rdc(rst_idx[i], 32'h0);
    // phase chosen before the device is taken to play
    wr(IDX_PHASE_CTRL, 32'h08);
    rdc(IDX_PHASE_CTRL, 32'h08);
    for (int c = 0; c < 4; c++)
    begin
      pwr <= 8'(c);
      repeat (3) @(posedge mclk_i);
      rdc(IDX_POWER_STATE, 32'(c));
    end
    lm <= 1'b1;
    repeat (3) @(posedge mclk_i);
    rdc(IDX_MUTE_REPORT, 32'h1);
    rm <= 1'b1;
    repeat (3) @(posedge mclk_i);
    rdc(IDX_MUTE_REPORT, 32'h3);
    wr(IDX_PHASE_CTRL, 32'hffffffff);
    rdc(IDX_PHASE_CTRL, 32'h0f);
    for (int p = 0; p < 4; p++)
    begin
      wr(IDX_PHASE_CTRL, 32'({p[1:0], 2'b10}));
      @(negedge mclk_i);
      chk("ramp_phase", 32'(p), 32'(ph));
      chk("sync_src_en", 32'h2, 32'({ssrc, sen}));
    end
    foreach (sm[i])
    begin
      wr(IDX_SPREAD_MODE, 32'(sm[i]));
      rdc(IDX_SPREAD_MODE, 32'(sm[i] & 8'h33));
      @(negedge mclk_i);
      chk("div2", 32'(sm[i][5] & sm[i][4]), 32'(sdiv));
      chk("manual", 32'(sm[i][4]), 32'(sman));
      chk("spread_en", 32'(sm[i][1:0]), 32'({srnd, stri}));
    end
    wr(IDX_SPREAD_SHAPE, 32'hff);
    rdc(IDX_SPREAD_SHAPE, 32'h7f);
    wr(IDX_SPREAD_SHAPE, 32'h5a);
    @(negedge mclk_i);
    chk("shape", 32'h5a, 32'({dith, tset}));
    apb(1'b1, ba(IDX_SPREAD_SHAPE), 32'h0, 4'h0);
    rdc(IDX_SPREAD_SHAPE, 32'h5a);
    apb(1'b0, 12'h1b4, 32'h0, 4'h0);
    chk("unmapped", 32'h1, {rdat[30:0], rerr});
    apb(1'b0, 12'h1a9, 32'h0, 4'h0);
    chk("misaligned", 32'h1, {rdat[30:0], rerr});
    wr(IDX_POWER_STATE, 32'hff);
    rdc(IDX_POWER_STATE, 32'h3);
    // events so far: both mute rises and state changes
    wr(IDX_IRQ_ENABLE, 32'hf);
    rdc(IDX_IRQ_ENABLE, 32'hf);
    rdc(IDX_IRQ_STATUS, 32'h7);
    wr(IDX_IRQ_CLEAR, 32'hf);
    rdc(IDX_IRQ_STATUS, 32'h0);
    chk("irq", 32'h0, 32'(irq));
    lm <= 1'b0;
    repeat (2) @(posedge mclk_i);
    lm <= 1'b1;
    repeat (3) @(posedge mclk_i);
    rdc(IDX_IRQ_STATUS, 32'h1);
    chk("irq", 32'h1, 32'(irq));
    wr(IDX_IRQ_ENABLE, 32'h0);
    @(negedge mclk_i);
    chk("irq", 32'h0, 32'(irq));
    wr(IDX_IRQ_CLEAR, 32'h1);
    rdc(IDX_IRQ_STATUS, 32'h0);
    // internal sync off, then on
    for (int e = 0; e < 2; e++)
    begin
      wr(IDX_PHASE_CTRL, 32'(2 + e));
      isy <= 1'b1;
      @(posedge mclk_i);
      isy <= 1'b0;
      @(negedge mclk_i);
      chk("sync_pulse", 32'(e), 32'(spul));
      rdc(IDX_IRQ_STATUS, 32'(e * 8));
    end
    wr(IDX_IRQ_CLEAR, 32'hf);
    wr(IDX_PHASE_CTRL, 32'h1);
    // internal pulse ignored while the pin is the source
    isy <= 1'b1;
    @(posedge mclk_i);
    isy <= 1'b0;
    @(negedge mclk_i);
    chk("sync_pin_src", 32'h0, 32'(spul));
    @(posedge mclk_i);
    spin <= 1'b1;
    n = 0;
    while (spul !== 1'b1 && n < 10)
    begin
      @(posedge mclk_i);
      n++;
    end
    chk("pin_pulse", 32'h1, 32'(spul));
    chk("pin_delay", 32'h4, 32'(n));
    conclude;
  end
endmodule // rpss_regs_tb

// ---- logic/rpss_pkg.sv ----
// constants and types of the ramp phase, spread and status register block
//****************************************************************************
// Summary of operation
// - power state reads as 8-bit code: 0 deep sleep, 1 sleep, 2 hi-z, 3 play.
// - mute report bit 1 is 1 while the right channel is auto-muted.
// - mute report bit 0 is 1 while the left channel is auto-muted.
// - phase bits 3:2 pick one of four ramp phases, 45 degrees apart.
// - phase bit 1 picks sync source: 0 pin, 1 internal.
// - phase bit 0 enables ramp phase sync; resets to 0.
// - spread bit 5 with manual mode selects pll clock divided by two.
// - spread bit 4 set puts spread controller in manual mode; reset automatic.
// - spread bit 1 enables random, bit 0 triangle modulation; both reset off.
// - shape bits 3:0 set triangle frequency and range, bits 6:4 dither.
//****************************************************************************
package rpss_pkg;

  //**************************************************************************
  // register indices; byte address is four times the index
  //**************************************************************************
  localparam logic [7:0] IDX_POWER_STATE  = 8'h68;
  localparam logic [7:0] IDX_MUTE_REPORT  = 8'h69;
  localparam logic [7:0] IDX_PHASE_CTRL   = 8'h6a;
  localparam logic [7:0] IDX_SPREAD_MODE  = 8'h6b;
  localparam logic [7:0] IDX_SPREAD_SHAPE = 8'h6c;
  localparam logic [7:0] IDX_IRQ_STATUS   = 8'h80;
  localparam logic [7:0] IDX_IRQ_CLEAR    = 8'h81;
  localparam logic [7:0] IDX_IRQ_ENABLE   = 8'h82;

  //**************************************************************************
  // field positions and writable masks
  //**************************************************************************
  localparam int POS_MUTE_LEFT   = 0;
  localparam int POS_MUTE_RIGHT  = 1;
  localparam int POS_SYNC_EN     = 0;
  localparam int POS_SYNC_SRC    = 1;
  localparam int POS_PHASE_LO    = 2;
  localparam int POS_TRI_EN      = 0;
  localparam int POS_RDM_EN      = 1;
  localparam int POS_MANUAL      = 4;
  localparam int POS_PRE_DIV     = 5;
  localparam int POS_TRI_LO      = 0;
  localparam int POS_DITHER_LO   = 4;

  localparam logic [7:0] MASK_PHASE_CTRL   = 8'h0f;
  localparam logic [7:0] MASK_SPREAD_MODE  = 8'h33;
  localparam logic [7:0] MASK_SPREAD_SHAPE = 8'h7f;

  //**************************************************************************
  // interrupt events
  //**************************************************************************
  localparam int N_EVENTS        = 4;
  localparam int EV_LEFT_MUTE    = 0;
  localparam int EV_RIGHT_MUTE   = 1;
  localparam int EV_STATE_CHANGE = 2;
  localparam int EV_SYNC_PULSE   = 3;

  //**************************************************************************
  // reset values
  //**************************************************************************
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [3:0] RST_IRQ  = 4'h0;

  typedef enum logic [7:0]
  {
    PWR_DEEP_SLEEP = 8'h00,
    PWR_SLEEP      = 8'h01,
    PWR_HIZ        = 8'h02,
    PWR_PLAY       = 8'h03
  } rpss_power_type;

endpackage

// ---- logic/rpss_regs.sv ----
// apb register bank for power/mute report, ramp phase and spread control
//
// Implementation choice: register access over APB.
`timescale 1ns/10ps
module rpss_regs
  import rpss_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input  wire logic              mclk_i,
  input  wire logic              reset_n_i,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // device status inputs, same clock
  input  wire logic [7:0]        power_state_code_i,
  input  wire logic              left_automute_flag_i,
  input  wire logic              right_automute_flag_i,
  input  wire logic              internal_sync_i,
  // sync pin, asynchronous
  input  wire logic              sync_pin_i,
  // ramp and spread controls, interrupt
  output logic      [1:0]        ramp_phase_o,
  output logic                   sync_source_internal_o,
  output logic                   sync_enable_o,
  output logic                   phase_sync_pulse_o,
  output logic                   spread_manual_o,
  output logic                   spread_clk_div2_o,
  output logic                   random_spread_on_o,
  output logic                   triangle_spread_on_o,
  output logic      [3:0]        triangle_setting_o,
  output logic      [2:0]        random_dither_setting_o,
  output logic                   irq_o
);

  //**************************************************************************
  // state
  //**************************************************************************
  typedef struct packed
  {
    logic [7:0]          phase_ctrl;
    logic [7:0]          spread_mode;
    logic [7:0]          spread_shape;
    logic [N_EVENTS-1:0] irq_enable;
    logic [31:0]         rdata;
    logic                slverr;
    logic [7:0]          state_prev;
    logic [1:0]          mute_prev;
    logic                pin_prev;
    logic                sync_pulse;
    logic [1:0]          mute_rpt;
    logic [7:0]          power_rpt;
  } rpss_regs_type;

  rpss_regs_type       regs_r;
  rpss_regs_type       regs_nxt;
  logic                sync_pin_s;
  logic [N_EVENTS-1:0] ev_set;
  logic [N_EVENTS-1:0] ev_clear;
  logic [N_EVENTS-1:0] ev_status;
  logic [7:0]          index;
  logic                aligned;
  logic                setup;
  logic                access;
  logic                wr_en;
  logic                sync_raw;

  //**************************************************************************
  // sync pin crossing
  //**************************************************************************
  rpss_sync2 u_sync_pin
  (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .async_i   (sync_pin_i),
    .sync_o    (sync_pin_s)
  );

  //**************************************************************************
  // event flags
  //**************************************************************************
  rpss_sticky #(.WIDTH(N_EVENTS)) u_events
  (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .set_i     (ev_set),
    .clear_i   (ev_clear),
    .enable_i  (regs_r.irq_enable),
    .status_o  (ev_status),
    .irq_o     (irq_o)
  );

  //**************************************************************************
  // bus decode
  //**************************************************************************
  assign index   = paddr[9:2];
  assign aligned = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == '0);
  assign setup   = psel && !penable;
  assign access  = psel && penable;
  assign wr_en   = access && pwrite && pstrb[0] && aligned && !regs_r.slverr;

  assign ev_clear = (wr_en && index == IDX_IRQ_CLEAR) ? pwdata[N_EVENTS-1:0] : '0;

  // pin sync uses its rising edge, internal sync is already a pulse
  assign sync_raw = regs_r.phase_ctrl[POS_SYNC_SRC] ? internal_sync_i
                                                    : (sync_pin_s && !regs_r.pin_prev);

  always_comb
  begin
    ev_set                  = '0;
    ev_set[EV_LEFT_MUTE]    = left_automute_flag_i && !regs_r.mute_prev[0];
    ev_set[EV_RIGHT_MUTE]   = right_automute_flag_i && !regs_r.mute_prev[1];
    ev_set[EV_STATE_CHANGE] = power_state_code_i != regs_r.state_prev;
    ev_set[EV_SYNC_PULSE]   = regs_r.sync_pulse;
  end

  //**************************************************************************
  // next state
  //**************************************************************************
  always_comb
  begin
    regs_nxt            = regs_r;
    regs_nxt.state_prev = power_state_code_i;
    regs_nxt.mute_prev  = {right_automute_flag_i, left_automute_flag_i};
    regs_nxt.pin_prev   = sync_pin_s;
    regs_nxt.power_rpt  = power_state_code_i;
    regs_nxt.mute_rpt[POS_MUTE_RIGHT] = right_automute_flag_i;
    regs_nxt.mute_rpt[POS_MUTE_LEFT]  = left_automute_flag_i;
    regs_nxt.sync_pulse = regs_r.phase_ctrl[POS_SYNC_EN] && sync_raw;

    // read data and error captured in the setup cycle
    if (setup)
    begin
      regs_nxt.rdata  = '0;
      regs_nxt.slverr = 1'b0;
      if (!aligned)
      begin
        regs_nxt.slverr = 1'b1;
      end
      else if (index == IDX_POWER_STATE)
      begin
        regs_nxt.rdata[7:0] = regs_r.power_rpt;
      end
      else if (index == IDX_MUTE_REPORT)
      begin
        regs_nxt.rdata[1:0] = regs_r.mute_rpt;
      end
      else if (index == IDX_PHASE_CTRL)
      begin
        regs_nxt.rdata[7:0] = regs_r.phase_ctrl;
      end
      else if (index == IDX_SPREAD_MODE)
      begin
        regs_nxt.rdata[7:0] = regs_r.spread_mode;
      end
      else if (index == IDX_SPREAD_SHAPE)
      begin
        regs_nxt.rdata[7:0] = regs_r.spread_shape;
      end
      else if (index == IDX_IRQ_STATUS)
      begin
        regs_nxt.rdata[N_EVENTS-1:0] = ev_status;
      end
      else if (index == IDX_IRQ_CLEAR)
      begin
        regs_nxt.rdata = '0;
      end
      else if (index == IDX_IRQ_ENABLE)
      begin
        regs_nxt.rdata[N_EVENTS-1:0] = regs_r.irq_enable;
      end
      else
      begin
        regs_nxt.slverr = 1'b1;
      end
    end

    // writes take effect at the access edge; reserved bits masked off
    if (wr_en)
    begin
      if (index == IDX_PHASE_CTRL)
      begin
        regs_nxt.phase_ctrl = pwdata[7:0] & MASK_PHASE_CTRL;
      end
      else if (index == IDX_SPREAD_MODE)
      begin
        regs_nxt.spread_mode = pwdata[7:0] & MASK_SPREAD_MODE;
      end
      else if (index == IDX_SPREAD_SHAPE)
      begin
        regs_nxt.spread_shape = pwdata[7:0] & MASK_SPREAD_SHAPE;
      end
      else if (index == IDX_IRQ_ENABLE)
      begin
        regs_nxt.irq_enable = pwdata[N_EVENTS-1:0];
      end
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      regs_r              <= '0;
      regs_r.phase_ctrl   <= RST_CTRL;
      regs_r.spread_mode  <= RST_CTRL;
      regs_r.spread_shape <= RST_CTRL;
      regs_r.irq_enable   <= RST_IRQ;
    end
    else
    begin
      regs_r <= regs_nxt;
    end
  end

  //**************************************************************************
  // outputs
  //**************************************************************************
  assign prdata  = regs_r.rdata;
  assign pready  = access;
  assign pslverr = access && regs_r.slverr;

  assign ramp_phase_o            = regs_r.phase_ctrl[POS_PHASE_LO +: 2];
  assign sync_source_internal_o  = regs_r.phase_ctrl[POS_SYNC_SRC];
  assign sync_enable_o           = regs_r.phase_ctrl[POS_SYNC_EN];
  assign phase_sync_pulse_o      = regs_r.sync_pulse;
  assign spread_manual_o         = regs_r.spread_mode[POS_MANUAL];
  assign spread_clk_div2_o       = regs_r.spread_mode[POS_MANUAL] && regs_r.spread_mode[POS_PRE_DIV];
  assign random_spread_on_o      = regs_r.spread_mode[POS_RDM_EN];
  assign triangle_spread_on_o    = regs_r.spread_mode[POS_TRI_EN];
  assign triangle_setting_o      = regs_r.spread_shape[POS_TRI_LO +: 4];
  assign random_dither_setting_o = regs_r.spread_shape[POS_DITHER_LO +: 3];

endmodule // rpss_regs

// ---- logic/rpss_sticky.sv ----
// sticky event flags with write-one-to-clear and enable gating
`timescale 1ns/10ps
module rpss_sticky
#(
  parameter int WIDTH = 4
)
(
  input  wire logic             mclk_i,
  input  wire logic             reset_n_i,
  input  wire logic [WIDTH-1:0] set_i,
  input  wire logic [WIDTH-1:0] clear_i,
  input  wire logic [WIDTH-1:0] enable_i,
  output logic      [WIDTH-1:0] status_o,
  output logic                  irq_o
);

  typedef struct packed
  {
    logic [WIDTH-1:0] flags;
  } rpss_sticky_type;

  rpss_sticky_type state_r;
  rpss_sticky_type state_nxt;

  always_comb
  begin
    state_nxt       = state_r;
    // set wins over a clear in the same cycle
    state_nxt.flags = (state_r.flags & ~clear_i) | set_i;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      state_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign status_o = state_r.flags;
  assign irq_o    = |(state_r.flags & enable_i);

endmodule // rpss_sticky

// ---- logic/rpss_sync2.sv ----
// two-flop synchroniser for one level from outside the clock domain
`timescale 1ns/10ps
module rpss_sync2
(
  input  wire logic mclk_i,
  input  wire logic reset_n_i,
  input  wire logic async_i,
  output logic      sync_o
);

  typedef struct packed
  {
    logic first;
    logic second;
  } rpss_sync_type;

  rpss_sync_type state_r;
  rpss_sync_type state_nxt;

  always_comb
  begin
    state_nxt        = state_r;
    state_nxt.first  = async_i;
    state_nxt.second = state_r.first;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      state_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign sync_o = state_r.second;

endmodule // rpss_sync2
